// ===== pkg/ir_rx_pkg.sv
// Purpose: shared types and constants of the infrared receive capture block
// Assumes: 32-bit Avalon-MM register bus, byte addresses, one word per reg
// Notes:   all offsets, reset values and limits are named here only

package ir_rx_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_CARRIER = 5'h04;
  localparam logic [4:0] OFS_VALUE = 5'h08;
  localparam logic [4:0] OFS_MODTIME = 5'h0C;
  localparam logic [4:0] OFS_DATA = 5'h10;
  localparam logic [4:0] OFS_STATUS = 5'h14;
  localparam logic [4:0] OFS_MASK = 5'h18;

  // ----------------------------------------------------------------------
  // Values and limits
  // ----------------------------------------------------------------------
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] MODTIME_SEED = 16'h0001;
  localparam logic [15:0] CARRIER_RST = 16'h0000;
  localparam logic [1:0] GAP_LIMIT = 2'h2;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  // Edge select codes
  localparam logic [1:0] SEL_FALL = 2'h0;
  localparam logic [1:0] SEL_RISE = 2'h1;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_ARMED = 2'b01,
    RX_RUN = 2'b11
  } rx_state_t;

  // Control word, bit 0 upward: enable, direction, edge select, clock
  // source, reload, burst mode, interrupt enable, divider
  typedef struct packed {
    logic [1:0] infrared_clock_divider;
    logic infrared_interrupt_enable;
    logic burst_count_mode;
    logic counter_reload_on_edge;
    logic count_clock_source;
    logic [1:0] rx_edge_select;
    logic ir_direction_select;
    logic ir_timer_enable;
  } ctrl_t;

  typedef struct packed {
    logic counter_overflow_flag;
    logic capture_interrupt_flag;
  } status_t;

  localparam ctrl_t CTRL_RST = '0;

  typedef struct packed {
    rx_state_t st;
    ctrl_t ctrl;
    logic [15:0] carrier_register;
    logic [15:0] value_counter;
    logic [15:0] modulation_time_register;
    logic pin_level_bit;
    status_t status;
    status_t mask;
    logic pin_prev;
    logic burst_prev;
    logic [2:0] div_cnt;
    logic [8:0] car_cnt;
    logic [1:0] gap;
    logic waitrequest;
    logic [31:0] readdata;
    logic irq;
  } state_t;

endpackage : ir_rx_pkg

// ===== rtl/ir_receive_capture.sv
// Purpose: infrared receive capture timer with carrier burst-count mode
// Assumes: receive pin synchronous to i_sys_clk; Avalon-MM slave port
// Notes:   every answer takes one wait cycle; flags clear by writing one
//
// Functional notes
// - Receive mode runs while direction is 0 and enable is 1.
// - Two-bit edge select picks which pin transitions are captures.
// - Value counter starts from zero at the first qualified event.
// - Counter steps per carrier cycle, or per infrared clock tick.
// - Each qualified event stores pin level: 0 falling, 1 rising.
// - Standard mode copies the value counter into modulation time.
// - Reload set clears the counter on events, else it runs on.
// - Counter wrap from FFFF on a cycle with no qualified event sets overflow flag and may interrupt.
// - Receive stops when direction goes to transmit or enable clears.
// - Standard mode sets the capture flag on every capture.
// - Burst mode stops counter capture and capture flag meaning.
// - Burst mode makes modulation time count qualified edges.
// - Burst mode flags a space after two edgeless carrier cycles.
// - Entering burst mode seeds modulation time with one.
// - Clock source and reload still apply in burst mode.
// - Infrared clock is system clock divided by two to the divider.
// - Carrier cycle lasts high plus low byte plus two ticks.
// - Interrupt reaches the processor only while interrupt enable bit is set.
//
// Our own choices: the Avalon-MM slave port and the placing of the registers.

`timescale 1ns/1ns

module ir_receive_capture
  import ir_rx_pkg::*;
(
  input wire logic i_sys_clk, // System clock, 50 MHz
  input wire logic i_rst_b, // Asynchronous reset, active low
  input wire logic [4:0] i_address, // Byte address
  input wire logic i_read, // Read request
  input wire logic i_write, // Write request
  input wire logic [31:0] i_writedata, // Write data
  input wire logic [3:0] i_byteenable, // Byte lanes of a write
  output logic [31:0] o_readdata, // Read data, valid with wait low
  output logic o_waitrequest, // Low for the answering cycle
  input wire logic i_infrared_receive_pin, // Detector output
  output logic o_irq // Level interrupt
);

  // ----------------------------------------------------------------------
  // State and derived timing
  // ----------------------------------------------------------------------
  state_t s_q;
  state_t s_d;
  logic [2:0] div_mask;
  logic ir_tick;
  logic [8:0] car_last;
  logic car_end;
  logic cnt_en;
  logic rx_on;
  logic rise;
  logic fall;
  logic qual;
  logic [31:0] be_mask;

  // Divider mask is all ones below the divider power
  assign div_mask = 3'((4'h1 << s_q.ctrl.infrared_clock_divider) - 4'h1);
  assign ir_tick = (s_q.div_cnt & div_mask) == div_mask;
  // Last tick index of a carrier cycle: two extra ticks over the bytes
  assign car_last = {1'b0, s_q.carrier_register[15:8]}
                  + {1'b0, s_q.carrier_register[7:0]} + 9'h001;
  assign car_end = ir_tick && (s_q.car_cnt == car_last);
  // Counter clock: carrier cycle or raw infrared tick
  assign cnt_en = s_q.ctrl.count_clock_source ? ir_tick : car_end;
  assign rx_on = s_q.ctrl.ir_timer_enable
              && !s_q.ctrl.ir_direction_select;
  assign rise = i_infrared_receive_pin && !s_q.pin_prev;
  assign fall = !i_infrared_receive_pin && s_q.pin_prev;
  assign be_mask = {{8{i_byteenable[3]}}, {8{i_byteenable[2]}},
                    {8{i_byteenable[1]}}, {8{i_byteenable[0]}}};

  // Edge qualification; codes 2 and 3 both take either edge
  always_comb begin
    if (s_q.ctrl.rx_edge_select == SEL_FALL) begin
      qual = fall;
    end else if (s_q.ctrl.rx_edge_select == SEL_RISE) begin
      qual = rise;
    end else begin
      qual = rise || fall;
    end
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  // Bus side is handled first so that a hardware set in the same cycle
  // overrides a software clear of the same flag.
  always_comb begin
    s_d = s_q;
    s_d.pin_prev = i_infrared_receive_pin;
    s_d.burst_prev = s_q.ctrl.burst_count_mode;
    s_d.div_cnt = s_q.div_cnt + 3'h1;

    // Bus slave: one wait cycle, writes commit when wait is low
    if ((i_read || i_write) && s_q.waitrequest) begin
      s_d.waitrequest = 1'b0;
      if (!i_read) begin
        s_d.readdata = READ_ZERO;
      end else if (i_address == OFS_CTRL) begin
        s_d.readdata = 32'(s_q.ctrl);
      end else if (i_address == OFS_CARRIER) begin
        s_d.readdata = 32'(s_q.carrier_register);
      end else if (i_address == OFS_VALUE) begin
        s_d.readdata = 32'(s_q.value_counter);
      end else if (i_address == OFS_MODTIME) begin
        s_d.readdata = 32'(s_q.modulation_time_register);
      end else if (i_address == OFS_DATA) begin
        s_d.readdata = 32'(s_q.pin_level_bit);
      end else if (i_address == OFS_STATUS) begin
        s_d.readdata = 32'(s_q.status);
      end else if (i_address == OFS_MASK) begin
        s_d.readdata = 32'(s_q.mask);
      end else begin
        s_d.readdata = READ_ZERO; // Unmapped reads as zero
      end
    end else begin
      s_d.waitrequest = 1'b1;
      if (i_write && !s_q.waitrequest) begin
        if (i_address == OFS_CTRL) begin
          s_d.ctrl = ctrl_t'(10'((32'(s_q.ctrl) & ~be_mask)
                    | (i_writedata & be_mask)));
        end else if (i_address == OFS_CARRIER) begin
          s_d.carrier_register = 16'(
            (32'(s_q.carrier_register) & ~be_mask)
            | (i_writedata & be_mask));
        end else if (i_address == OFS_STATUS) begin
          // Write one to clear, held until then
          s_d.status = s_q.status
                     & ~status_t'(2'(i_writedata & be_mask));
        end else if (i_address == OFS_MASK) begin
          s_d.mask = status_t'(2'(i_writedata & be_mask));
        end
      end
    end

    // Carrier cycle timer, restarted whenever receive is off
    if (!rx_on) begin
      s_d.car_cnt = 9'h000;
    end else if (ir_tick) begin
      s_d.car_cnt = car_end ? 9'h000 : s_q.car_cnt + 9'h001;
    end

    // Receive sequencer
    case (s_q.st)
      RX_IDLE: begin
        s_d.value_counter = COUNT_ZERO;
        if (rx_on) begin
          s_d.st = RX_ARMED;
        end
      end
      RX_ARMED: begin
        if (!rx_on) begin
          s_d.st = RX_IDLE;
        end else if (qual) begin
          s_d.st = RX_RUN;
          s_d.value_counter = COUNT_ZERO;
          s_d.pin_level_bit = rise;
          s_d.gap = 2'h0;
        end
      end
      RX_RUN: begin
        if (!rx_on) begin
          s_d.st = RX_IDLE;
        end else if (qual) begin
          s_d.pin_level_bit = rise;
          s_d.gap = 2'h0;
          if (s_q.ctrl.burst_count_mode) begin
            s_d.modulation_time_register =
              s_q.modulation_time_register + 16'h0001;
          end else begin
            s_d.modulation_time_register = s_q.value_counter;
            s_d.status.capture_interrupt_flag = 1'b1;
          end
          if (s_q.ctrl.counter_reload_on_edge) begin
            s_d.value_counter = COUNT_ZERO;
          end else if (cnt_en) begin
            s_d.value_counter = s_q.value_counter + 16'h0001;
          end
        end else begin
          if (cnt_en) begin
            if (s_q.value_counter == COUNT_MAX) begin
              s_d.status.counter_overflow_flag = 1'b1;
            end
            s_d.value_counter = s_q.value_counter + 16'h0001;
          end
          // Space detect counts carrier cycles, flags once per space
          if (s_q.ctrl.burst_count_mode && car_end
              && s_q.gap != GAP_LIMIT) begin
            s_d.gap = s_q.gap + 2'h1;
            if (s_q.gap + 2'h1 == GAP_LIMIT) begin
              s_d.status.capture_interrupt_flag = 1'b1;
            end
          end
        end
      end
      default: begin
        s_d.st = RX_IDLE;
      end
    endcase

    // Entering burst mode seeds the edge count
    if (s_q.ctrl.burst_count_mode && !s_q.burst_prev) begin
      s_d.modulation_time_register = MODTIME_SEED;
    end

    // Interrupt level from next status so it tracks the flags exactly
    s_d.irq = s_d.ctrl.infrared_interrupt_enable
            && |(s_d.status & s_d.mask);
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s_q <= '{st: RX_IDLE, ctrl: CTRL_RST, carrier_register: CARRIER_RST,
               value_counter: COUNT_ZERO,
               modulation_time_register: COUNT_ZERO,
               waitrequest: 1'b1, readdata: READ_ZERO, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign o_readdata = s_q.readdata;
  assign o_waitrequest = s_q.waitrequest;
  assign o_irq = s_q.irq;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);

  a_bus_answer: assert property (
    (i_read || i_write) && o_waitrequest |=> !o_waitrequest ##1 o_waitrequest)
    else $error("bus answer not after one wait cycle");

  a_capture_copy: assert property (
    s_q.st == RX_RUN && rx_on && qual && !s_q.ctrl.burst_count_mode
    && s_q.burst_prev == 1'b0
    |=> s_q.modulation_time_register == $past(s_q.value_counter))
    else $error("capture did not copy counter");

  a_capture_flag: assert property (
    s_q.st == RX_RUN && rx_on && qual && !s_q.ctrl.burst_count_mode
    |=> s_q.status.capture_interrupt_flag)
    else $error("capture flag not set");

  a_level_bit: assert property (
    s_q.st != RX_IDLE && rx_on && qual
    |=> s_q.pin_level_bit == $past(i_infrared_receive_pin))
    else $error("pin level not recorded");

  a_reload_clear: assert property (
    s_q.st == RX_RUN && rx_on && qual && s_q.ctrl.counter_reload_on_edge
    |=> s_q.value_counter == COUNT_ZERO)
    else $error("counter not cleared on edge");

  a_overflow_set: assert property (
    s_q.st == RX_RUN && rx_on && !qual && cnt_en
    && s_q.value_counter == COUNT_MAX
    |=> s_q.status.counter_overflow_flag && s_q.value_counter == COUNT_ZERO)
    else $error("overflow not flagged");

  a_burst_seed: assert property (
    $rose(s_q.ctrl.burst_count_mode)
    |=> s_q.modulation_time_register == MODTIME_SEED)
    else $error("burst entry did not seed");

  a_stop_rx: assert property (
    !rx_on |=> s_q.st == RX_IDLE)
    else $error("receive did not stop");

  a_irq_gate: assert property (
    o_irq |-> s_q.ctrl.infrared_interrupt_enable
    && |(s_q.status & s_q.mask))
    else $error("interrupt without enabled flag");

  a_arm_zero: assert property (
    s_q.st == RX_ARMED |-> s_q.value_counter == COUNT_ZERO)
    else $error("counter moved before first event");

endmodule : ir_receive_capture

// ===== testbench/ir_detector_model.sv
// Purpose: model of the infrared detector output feeding the receive pin
// Assumes: detector output is synchronous to the system clock
// Notes:   idles high, as a detector does with no carrier in view
`timescale 1ns/1ns
module ir_detector_model (
  input wire logic i_sys_clk, // System clock
  input wire logic i_rst_b, // Reset, active low
  input wire logic i_level, // Level asked for by the bench
  output logic o_pin // Detector output
);
  // Registered so every pin edge lands just after a clock edge
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pin <= 1'b1;
    end else begin
      o_pin <= i_level;
    end
  end
endmodule : ir_detector_model

// ===== testbench/ir_receive_capture_test.sv
// Purpose: self-checking bench for the infrared receive capture block
// Assumes: one wait cycle per bus answer is not relied on
// Notes:   timing checks allow a small window for edge detect latency
`timescale 1ns/1ns
module ir_receive_capture_test;
  import ir_rx_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic lvl = 1'b1;
  logic pin;
  logic wait_b;
  logic irq;
  logic [4:0] adr = 5'h00;
  logic [31:0] wd = 32'h0000_0000;
  logic [31:0] rdata;
  logic [31:0] q;
  logic [31:0] cw;
  int fail_count = 0;
  int total_checks = 0;
  int k1;
  int k2;

  // ----------------------------------------------------------------------
  // Clock, device and detector
  // ----------------------------------------------------------------------
  initial begin
    forever #10 sys_clk = !sys_clk;
  end

  ir_receive_capture DUT (.i_sys_clk(sys_clk), .i_rst_b(rst_b),
    .i_address(adr), .i_read(rd), .i_write(wr), .i_writedata(wd),
    .i_byteenable(4'hF), .o_readdata(rdata), .o_waitrequest(wait_b),
    .i_infrared_receive_pin(pin), .o_irq(irq));

  ir_detector_model det (.i_sys_clk(sys_clk), .i_rst_b(rst_b),
    .i_level(lvl), .o_pin(pin));

  // ----------------------------------------------------------------------
  // Tasks and functions
  // ----------------------------------------------------------------------
  task wrap_up;
    if (fail_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Request held until waitrequest is sampled low at a rising edge
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    wr <= w;
    rd <= !w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wait_b !== 1'b0 && n < 40);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    if (n >= 40) begin
      fail_count++;
      wrap_up();
    end
  endtask : bus

  // Flip the detector level, then let n clocks pass
  task tog(input int n);
    @(posedge sys_clk);
    lvl <= !lvl;
    repeat (n) @(posedge sys_clk);
  endtask : tog

  function automatic logic [31:0] mk(input logic [1:0] sel, input logic src,
    input logic rl, input logic bst, input logic [1:0] dv);
    ctrl_t c;
    c = CTRL_RST;
    c.ir_timer_enable = 1'b1;
    c.rx_edge_select = sel;
    c.count_clock_source = src;
    c.counter_reload_on_edge = rl;
    c.burst_count_mode = bst;
    c.infrared_interrupt_enable = 1'b1;
    c.infrared_clock_divider = dv;
    return {22'h000000, c};
  endfunction : mk

  function automatic logic [31:0] inr(input logic [31:0] v, input int lo,
    input int hi);
    return {31'h0, (v >= lo && v <= hi)};
  endfunction : inr

  // Restart receive, arm on one edge, capture on the next two
  task run(input logic [31:0] c, input int g1, input int g2);
    bus(1'b1, OFS_CTRL, 32'h0);
    bus(1'b1, OFS_STATUS, 32'h3);
    bus(1'b1, OFS_CTRL, c);
    tog(g1);
    tog(g2);
    tog(4);
    bus(1'b0, OFS_MODTIME, 32'h0);
  endtask : run

  // ----------------------------------------------------------------------
  // Watchdog: the overflow case alone needs some 65600 clocks
  // ----------------------------------------------------------------------
  initial begin
    repeat (90000) @(posedge sys_clk);
    fail_count++;
    wrap_up();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    void'($urandom(64602));
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      bus(1'b0, 5'(a * 4), 32'h0);
      chk(q, 32'h0);
    end
    chk({31'h0, irq}, 32'h0);
    k1 = $urandom % 65536;
    bus(1'b1, OFS_CARRIER, 32'(k1));
    bus(1'b0, OFS_CARRIER, 32'h0);
    chk(q, 32'(k1));
    bus(1'b1, OFS_VALUE, 32'hFFFF_FFFF);
    bus(1'b0, OFS_VALUE, 32'h0);
    chk(q, 32'h0);
    // Edge select codes, then the transmit direction, which must stay deaf
    for (int i = 0; i < 5; i++) begin
      cw = mk((i == 4) ? 2'h2 : i[1:0], 1'b1, 1'b1, 1'b0, 2'h0);
      bus(1'b1, OFS_CTRL, 32'h0);
      bus(1'b1, OFS_STATUS, 32'h3);
      bus(1'b1, OFS_CTRL, cw | ((i == 4) ? 32'h2 : 32'h0));
      tog(4);
      tog(4);
      // Falling select sees a third edge, so a swapped decode shows
      if (i == 0) begin
        tog(4);
      end
      bus(1'b0, OFS_STATUS, 32'h0);
      chk(q, {31'h0, (i == 0 || i == 2 || i == 3)});
    end
    bus(1'b1, OFS_MASK, 32'h3);
    k1 = 5 + $urandom % 40;
    k2 = 5 + $urandom % 40;
    run(mk(2'h2, 1'b1, 1'b1, 1'b0, 2'h0), k1, k2);
    chk(inr(q, k2 - 1, k2 + 2), 32'h1);
    bus(1'b0, OFS_DATA, 32'h0);
    chk(q, {31'h0, lvl});
    bus(1'b0, OFS_STATUS, 32'h0);
    chk(q, 32'h1);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, OFS_STATUS, 32'h1);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk(q, 32'h0);
    chk({31'h0, irq}, 32'h0);
    run(mk(2'h3, 1'b1, 1'b0, 1'b0, 2'h0), k1, k2);
    chk(inr(q, k1 + k2, k1 + k2 + 4), 32'h1);
    bus(1'b0, OFS_DATA, 32'h0);
    chk(q, {31'h0, lvl});
    // Carrier of 4 ticks at half rate: one count per 8 clocks
    bus(1'b1, OFS_CARRIER, 32'h0101);
    k1 = 3 + $urandom % 8;
    k2 = 3 + $urandom % 8;
    run(mk(2'h2, 1'b0, 1'b1, 1'b0, 2'h1), 8 * k1, 8 * k2);
    chk(inr(q, k2 - 1, k2 + 1), 32'h1);
    // Long quiet spell wraps the counter; mask first holds irq low
    bus(1'b1, OFS_MASK, 32'h1);
    bus(1'b1, OFS_CTRL, 32'h0);
    bus(1'b1, OFS_STATUS, 32'h3);
    bus(1'b1, OFS_CTRL, mk(2'h2, 1'b1, 1'b0, 1'b0, 2'h0));
    tog(65545);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk(q, 32'h2);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, OFS_MASK, 32'h3);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h1);
    // Burst count: seed, count edges, then a space after two carriers
    bus(1'b1, OFS_CTRL, 32'h0);
    bus(1'b1, OFS_CTRL, mk(2'h2, 1'b0, 1'b1, 1'b0, 2'h1));
    bus(1'b1, OFS_CTRL, mk(2'h2, 1'b0, 1'b1, 1'b1, 2'h1));
    bus(1'b0, OFS_MODTIME, 32'h0);
    chk(q, 32'h1);
    bus(1'b1, OFS_STATUS, 32'h3);
    tog(1);
    tog(1);
    tog(1);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk(q, 32'h0);
    bus(1'b0, OFS_MODTIME, 32'h0);
    chk(inr(q, 3, 4), 32'h1);
    repeat (40) @(posedge sys_clk);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk(q, 32'h1);
    // Carrier cycles of 8 clocks since the last edge: 49 clocks give 6 or 7
    bus(1'b0, OFS_VALUE, 32'h0);
    chk(inr(q, 6, 7), 32'h1);
    wrap_up();
  end
endmodule : ir_receive_capture_test
